// File: include/rtf_consts.vh
// register offsets, field positions, reset values and timing counts for the tuning/rds flag block
`ifndef RTF_CONSTS_VH
`define RTF_CONSTS_VH
// register byte addresses
`define RTF_FLAG_ADDR 8'h00
`define RTF_MASK_ADDR 8'h04
`define RTF_CTRL_ADDR 8'h08
`define RTF_LEVEL_ADDR 8'h0C
`define RTF_STATUS_ADDR 8'h10
`define RTF_LAST_ADDR 8'h14
`define RTF_PREV_ADDR 8'h18
// flag / mask bit positions
`define RTF_B_LEVEL 0
`define RTF_B_TUNE 1
`define RTF_B_BAND 2
`define RTF_B_AVAIL 3
`define RTF_B_LOCK 4
// control field positions
`define RTF_C_THR_LO 0
`define RTF_C_HYS 2
`define RTF_C_MODE_LO 3
// status bit positions
`define RTF_S_OVF 0
`define RTF_S_SYNC 1
// data-available mode encodings
`define RTF_MODE_STD 2'h0
`define RTF_MODE_FAST 2'h1
`define RTF_MODE_HALF 2'h2
// reset values
`define RTF_CTRL_RST 5'h00
`define RTF_MASK_RST 5'h00
// timing: level period in ns, clock period in ns
`define RTF_LEVEL_PERIOD_NS 500000
`define RTF_CLK_NS 5
`define RTF_LEVEL_CYCLES (`RTF_LEVEL_PERIOD_NS / `RTF_CLK_NS)
// hysteresis offsets added to base threshold
`define RTF_HYS_SMALL 4'h1
`define RTF_HYS_LARGE 4'h2
// threshold setting that disables post-algorithm compare
`define RTF_THR_OFF 2'h3
`endif

// File: design/rtf_flags.v
// flag, interrupt and rds block hand-over logic with an ahb-lite register slave
// Function
// - level converted to 4 bits, readable over the bus
// - during tuning compare level with threshold field, flag when below
// - after algorithm use hysteresis threshold, compare every 500 us
// - hysteresis threshold from threshold field and hysteresis select bit
// - threshold setting 3 after search or preset makes compare threshold zero
// - level flag cleared by mask byte read and by tuning start
// - tune done flag set at algorithm finish, cleared by mask read
// - band end flag set at band end or lock fail, cleared by mask read
// - interrupt line only pulled low, when any unmasked flag set
// - standard mode: each block goes to registers, interrupt, avail flag
// - avail flag cleared by block register read, held until then
// - new block shifts last into previous, new into last
// - block shifted in while unread sets overflow bit
// - read while block buffered moves buffered block into last, clears overflow
// - reading last block register clears overflow
// - fast mode unsynced: avail flag withheld until A or C-prime block
// - two good blocks in valid order: sync bit set, interrupt raised
// - fast mode: no B block, next A or C-prime block flagged again
// - fast mode synced: every block sets avail flag and interrupt
// - halved mode: avail flag after every two new blocks
// - mask read clears all masks except lock-lost mask
// - repeated event on a set flag gives no further interrupt, except block avail events, which re-assert it
`timescale 1ns/10ps
`default_nettype none
`include "rtf_consts.vh"
module rtf_flags #(
    parameter LEVEL_CYCLES = `RTF_LEVEL_CYCLES,
    parameter BLK_W = 16
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // tuning engine events, same clock
    input wire tune_start,
    input wire tune_step,
    input wire tune_done,
    input wire tune_is_af,
    input wire band_end,
    input wire lock_fail,
    input wire [3:0] level_adc,
    // rds decoder, same clock
    input wire blk_valid,
    input wire [BLK_W-1:0] blk_data,
    input wire blk_is_a,
    input wire blk_is_b,
    input wire sync_good,
    input wire sync_lost,
    // open-drain interrupt line
    input wire irq_n_line_in,
    output wire irq_n_line_out,
    output wire irq_n_line_oe,
    // level conversion request to the adc
    output reg level_sample_q
);
    localparam CW = 24;
    // register map, one word each, low bits used
    //   0x00 flags: level, tune done, band end, block avail, lock lost
    //   0x04 masks, same bit order; read clears all but lock-lost mask
    //   0x08 control: threshold field, hysteresis select, avail mode
    //   0x0C last converted level
    //   0x10 status: overflow, sync, sampled line
    //   0x14 last block; read clears avail and overflow, loads buffer
    //   0x18 previous block; read clears avail
    // bus timing
    //   zero wait states, response always okay
    //   read data registered at the address phase edge
    //   writes and read side effects land at the data phase edge
    //   hsize ignored, whole words only
    // interrupt hazards
    //   line is open drain, only ever pulled low
    //   a flag already set gives no second assertion, except block avail events
    //   a mask read drops the line at once
    //   lock-lost mask survives that read, so sync loss stays visible
    // overflow handling
    //   block while avail set still shifts, overflow raised
    //   block while overflow set waits in a one-deep buffer
    //   last-block read then loads that buffer and clears overflow
    //   a further block while buffered overwrites the buffer
    // bus side
    reg ph_wr_q, ph_rd_q;
    reg [7:0] ph_addr_q;
    reg [4:0] flag_q, mask_q, ctrl_q;
    reg [3:0] level_q;
    reg sync_q, ovf_q, hys_mode_q, thr_zero_q, pend_q, half_cnt_q, fast_seen_a_q;
    reg [BLK_W-1:0] last_block_reg_q, previous_block_reg_q, pend_blk_q;
    reg [CW-1:0] tick_q;
    reg [4:0] flag_d;
    reg irq_q;
    wire acc = hsel & hready & htrans[1];
    wire rd_mask = ph_rd_q & (ph_addr_q == `RTF_MASK_ADDR);
    wire rd_last = ph_rd_q & (ph_addr_q == `RTF_LAST_ADDR);
    wire rd_prev = ph_rd_q & (ph_addr_q == `RTF_PREV_ADDR);
    wire rd_blk = rd_last | rd_prev;
    wire [1:0] mode = ctrl_q[`RTF_C_MODE_LO+1:`RTF_C_MODE_LO];
    wire [1:0] thr_fld = ctrl_q[`RTF_C_THR_LO+1:`RTF_C_THR_LO];
    wire tick = (tick_q == LEVEL_CYCLES - 1);

    // threshold value from field, optionally with hysteresis
    //   field scaled by four, so the 4-bit level spans all settings
    //   hysteresis adds a small or large step above the base
    //   result stays inside 4 bits for every field value
    function [3:0] thr_of;
        input [1:0] fld;
        input hys;
        input use_hys;
        reg [3:0] base;
        begin
            base = {fld, 2'h0};
            if (!use_hys) begin
                thr_of = base;
            end else if (hys) begin
                thr_of = base + `RTF_HYS_LARGE;
            end else begin
                thr_of = base + `RTF_HYS_SMALL;
            end
        end
    endfunction

    wire [3:0] thr_now = thr_zero_q ? 4'h0 : thr_of(thr_fld, ctrl_q[`RTF_C_HYS], hys_mode_q);
    wire level_low = level_adc < thr_now;
    // block arrives with a free slot when no overflow pending
    //   once overflow is up, the next block goes to the buffer instead
    //   keeps last and previous intact until the host catches up
    wire blk_shift = blk_valid & ~ovf_q;
    // avail qualification per mode
    reg avail_evt;
    always @* begin
        avail_evt = 1'b0;
        case (mode)
            `RTF_MODE_FAST: begin
                if (sync_q) begin
                    avail_evt = blk_shift;
                end else begin
                    avail_evt = blk_shift & blk_is_a;
                end
            end
            `RTF_MODE_HALF: avail_evt = blk_shift & half_cnt_q;
            default: avail_evt = blk_shift;
        endcase
        if (sync_good & ~sync_q) begin
            avail_evt = 1'b1;
        end
    end

    // flag next state: set wins over clear
    //   clears first, sets after, so an event in the clearing
    //   cycle is never lost
    //   lock-lost flag only set while its mask is on
    always @* begin
        flag_d = flag_q;
        if (rd_mask) begin
            flag_d[`RTF_B_LEVEL] = 1'b0;
            flag_d[`RTF_B_TUNE] = 1'b0;
            flag_d[`RTF_B_BAND] = 1'b0;
            flag_d[`RTF_B_LOCK] = 1'b0;
        end
        if (tune_start) begin
            flag_d[`RTF_B_LEVEL] = 1'b0;
        end
        if (rd_blk) begin
            flag_d[`RTF_B_AVAIL] = 1'b0;
        end
        if (level_sample_q & level_low) begin
            flag_d[`RTF_B_LEVEL] = 1'b1;
        end
        if (tune_done) begin
            flag_d[`RTF_B_TUNE] = 1'b1;
        end
        if (band_end | lock_fail) begin
            flag_d[`RTF_B_BAND] = 1'b1;
        end
        if (avail_evt) begin
            flag_d[`RTF_B_AVAIL] = 1'b1;
        end
        if (sync_lost & mask_q[`RTF_B_LOCK]) begin
            flag_d[`RTF_B_LOCK] = 1'b1;
        end
    end

    // ahb address phase capture
    //   remembers direction and address for the data phase
    //   address held between transfers, only qualifiers drop
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_q <= 1'b0;
            ph_rd_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else begin
            ph_wr_q <= acc & hwrite;
            ph_rd_q <= acc & ~hwrite;
            ph_addr_q <= acc ? haddr : ph_addr_q;
        end
    end

    // control, mask and flag registers
    //   a mask write in the same cycle as a mask read takes priority
    //   control field written whole, no read side effects
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `RTF_CTRL_RST;
            mask_q <= `RTF_MASK_RST;
            flag_q <= 5'h00;
        end else begin
            flag_q <= flag_d;
            if (ph_wr_q & (ph_addr_q == `RTF_CTRL_ADDR)) begin
                ctrl_q <= hwdata[4:0];
            end
            if (ph_wr_q & (ph_addr_q == `RTF_MASK_ADDR)) begin
                mask_q <= hwdata[4:0];
            end else if (rd_mask) begin
                mask_q <= mask_q & (5'h01 << `RTF_B_LOCK);
            end
        end
    end

    // level sampling: tuning-time compare and periodic hysteresis compare
    //   a tuning step asks for one compare on the plain threshold
    //   after an algorithm the periodic tick takes over
    //   tuning start restarts the tick, first compare a full period away
    //   sample pulse lines up with the adc value of the same cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hys_mode_q <= 1'b0;
            thr_zero_q <= 1'b0;
            tick_q <= {CW{1'b0}};
            level_sample_q <= 1'b0;
            level_q <= 4'h0;
        end else begin
            tick_q <= (tick | tune_start) ? {CW{1'b0}} : tick_q + 1'b1;
            level_sample_q <= tune_step | (hys_mode_q & tick);
            if (level_sample_q) begin
                level_q <= level_adc;
            end
            if (tune_start) begin
                hys_mode_q <= 1'b0;
                thr_zero_q <= 1'b0;
            end else if (tune_done) begin
                hys_mode_q <= 1'b1;
                thr_zero_q <= (thr_fld == `RTF_THR_OFF) & ~tune_is_af;
            end
        end
    end

    // rds block registers, overflow and sync
    //   buffered block load has priority over a block arriving then
    //   sync loss beats sync gain in the same cycle
    //   halved-rate counter only steps on shifted blocks
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_block_reg_q <= {BLK_W{1'b0}};
            previous_block_reg_q <= {BLK_W{1'b0}};
            pend_blk_q <= {BLK_W{1'b0}};
            pend_q <= 1'b0;
            ovf_q <= 1'b0;
            sync_q <= 1'b0;
            half_cnt_q <= 1'b0;
            fast_seen_a_q <= 1'b0;
        end else begin
            if (sync_lost) begin
                sync_q <= 1'b0;
            end else if (sync_good) begin
                sync_q <= 1'b1;
            end
            fast_seen_a_q <= blk_valid ? blk_is_a : fast_seen_a_q;
            if (rd_last & pend_q) begin
                previous_block_reg_q <= last_block_reg_q;
                last_block_reg_q <= pend_blk_q;
                pend_q <= 1'b0;
                ovf_q <= 1'b0;
            end else if (blk_shift) begin
                previous_block_reg_q <= last_block_reg_q;
                last_block_reg_q <= blk_data;
                half_cnt_q <= ~half_cnt_q;
                if (flag_q[`RTF_B_AVAIL]) begin
                    ovf_q <= 1'b1;
                end
            end else if (blk_valid) begin
                pend_blk_q <= blk_data; // held in the one-deep buffer
                pend_q <= ovf_q;
                ovf_q <= 1'b1;
            end else if (rd_last) begin
                ovf_q <= 1'b0;
            end
        end
    end

    // interrupt: one assertion per flag rising, blocked while flag set
    //   each qualified avail event re-asserts while its mask is on, even while avail stays set
    //   line released once no unmasked flag remains
    //   enable output registered, no glitch on the shared line
    wire [4:0] flag_rise = flag_d & ~flag_q & mask_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else if (rd_mask) begin
            irq_q <= 1'b0;
        end else if ((|flag_rise) | (avail_evt & mask_q[`RTF_B_AVAIL])) begin
            irq_q <= 1'b1;
        end else if (~|(flag_q & mask_q)) begin
            irq_q <= 1'b0;
        end
    end
    assign irq_n_line_out = 1'b0;
    assign irq_n_line_oe = irq_q;

    // line pin synchroniser: three stages, change taken when last two agree
    //   reset to the pulled-up idle level, so no false low after reset
    reg [2:0] line_sync_q;
    reg line_seen_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_sync_q <= 3'h7;
            line_seen_q <= 1'b1;
        end else begin
            line_sync_q <= {line_sync_q[1:0], irq_n_line_in};
            if (line_sync_q[2] == line_sync_q[1]) begin
                line_seen_q <= line_sync_q[2];
            end
        end
    end

    // read data mux
    //   registered at the address phase, stands through the data phase
    //   unmapped addresses read as zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (acc & ~hwrite) begin
            if (haddr == `RTF_FLAG_ADDR) begin
                hrdata <= {27'h0, flag_q};
            end else if (haddr == `RTF_MASK_ADDR) begin
                hrdata <= {27'h0, mask_q};
            end else if (haddr == `RTF_CTRL_ADDR) begin
                hrdata <= {27'h0, ctrl_q};
            end else if (haddr == `RTF_LEVEL_ADDR) begin
                hrdata <= {28'h0, level_q};
            end else if (haddr == `RTF_STATUS_ADDR) begin
                hrdata <= {29'h0, line_seen_q, sync_q, ovf_q};
            end else if (haddr == `RTF_LAST_ADDR) begin
                hrdata <= {{(32-BLK_W){1'b0}}, last_block_reg_q};
            end else if (haddr == `RTF_PREV_ADDR) begin
                hrdata <= {{(32-BLK_W){1'b0}}, previous_block_reg_q};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule // rtf_flags
`default_nettype wire

// File: bench/rtf_line.sv
// wired-or interrupt line with pull-up and a second open-drain device
`timescale 1ns/10ps
`default_nettype none
module rtf_line (
    // pull-down requests
    input wire logic oe,
    input wire logic other_pull,
    // resolved line
    output logic line
);
    // high through the pull-up unless a device sinks it
    assign line = (oe || other_pull) ? 1'b0 : 1'b1;
endmodule // rtf_line
`default_nettype wire

// File: bench/rtf_flags_sva.sv
// assertions on bus answer, interrupt line and flag clearing
`timescale 1ns/10ps
`default_nettype none
module rtf_flags_sva (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // events
    input wire logic tune_done,
    input wire logic band_end,
    input wire logic lock_fail,
    input wire logic blk_valid,
    input wire logic sync_good,
    input wire logic level_sample_q,
    // interrupt line
    input wire logic irq_n_line_out,
    input wire logic irq_n_line_oe
);
    logic ap_q, aw_q;
    logic [7:0] aa_q;
    logic [4:0] msk_q;
    logic [1:0] md_q;
    wire ap = hsel & hready & htrans[1];
    wire rd4 = ap & !hwrite & (haddr == 8'h04);
    wire rd0 = ap & !hwrite & (haddr == 8'h00);
    wire ev = tune_done | band_end | lock_fail;
    // shadow of mask and mode, updated in the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= 1'b0;
            aw_q <= 1'b0;
            aa_q <= 8'h00;
            msk_q <= 5'h00;
            md_q <= 2'h0;
        end else begin
            ap_q <= ap;
            aw_q <= hwrite;
            aa_q <= haddr;
            if (ap_q && aa_q == 8'h04) begin
                msk_q <= aw_q ? hwdata[4:0] : (msk_q & 5'h10);
            end
            if (ap_q && aw_q && aa_q == 8'h08) begin
                md_q <= hwdata[4:3];
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    a_line_low: assert property (irq_n_line_out == 1'b0) else $error("line driven high");
    a_oe_mask_rd: assert property (rd4 ##1 !(ev | blk_valid | sync_good | level_sample_q) |=> !irq_n_line_oe)
        else $error("line held after mask read");
    a_rd_clears: assert property (rd4 ##1 !ev ##1 rd0 |=> hrdata[2:1] == 2'h0)
        else $error("flags survive mask read");
    a_band_irq: assert property ((band_end | lock_fail) && msk_q[2] && !ap_q |=> irq_n_line_oe)
        else $error("band event without line");
    a_tune_irq: assert property (tune_done && msk_q[1] && !ap_q |=> irq_n_line_oe)
        else $error("tune done without line");
    a_blk_irq: assert property (blk_valid && msk_q[3] && md_q == 2'h0 && !ap_q |=> irq_n_line_oe)
        else $error("block without line");
    a_no_mask: assert property (msk_q == 5'h00 && !ap_q && !irq_n_line_oe |=> !irq_n_line_oe)
        else $error("line with all masked");
    cover property (rd4 ##1 !ev ##1 rd0);
    cover property (blk_valid && msk_q[3]);
    cover property ($rose(irq_n_line_oe));
endmodule // rtf_flags_sva
bind rtf_flags rtf_flags_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tune_done(tune_done), .band_end(band_end), .lock_fail(lock_fail), .blk_valid(blk_valid),
    .sync_good(sync_good), .level_sample_q(level_sample_q), .irq_n_line_out(irq_n_line_out),
    .irq_n_line_oe(irq_n_line_oe));
`default_nettype wire

// File: bench/rtf_flags_tb.sv
// testbench for the flag, interrupt and rds block logic
`timescale 1ns/10ps
`default_nettype none
module rtf_flags_tb;
    logic hclk, hresetn, hwrite, tune_start, tune_step, tune_done, tune_is_af, band_end, lock_fail;
    logic blk_valid, blk_is_a, blk_is_b, sync_good, sync_lost, pull_q, h;
    logic [1:0] htrans, f;
    logic [7:0] haddr;
    logic [31:0] hwdata, rd;
    logic [3:0] level_adc;
    logic [15:0] blk_data, bk [3];
    wire [31:0] hrdata;
    wire hready, line, oe;
    int failures = 0;
    int checks_done = 0;
    rtf_flags #(.LEVEL_CYCLES(20), .BLK_W(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(), .tune_start(tune_start), .tune_step(tune_step), .tune_done(tune_done),
        .tune_is_af(tune_is_af), .band_end(band_end), .lock_fail(lock_fail), .level_adc(level_adc),
        .blk_valid(blk_valid), .blk_data(blk_data), .blk_is_a(blk_is_a), .blk_is_b(blk_is_b),
        .sync_good(sync_good), .sync_lost(sync_lost), .irq_n_line_in(line), .irq_n_line_out(),
        .irq_n_line_oe(oe), .level_sample_q());
    rtf_line u_line (.oe(oe), .other_pull(pull_q), .line(line));
    // clock and watchdog
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    initial begin
        #100000;
        failures++;
        stop_test();
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one single bus transfer
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic ck(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        xf(1'b0, a, 32'h0);
        ck(rd & m, e);
    endtask
    // one-cycle event pulses, then settle
    task automatic ev(input logic [6:0] m, input logic [15:0] d);
        {sync_good, tune_start, tune_step, tune_done, band_end, lock_fail, blk_valid} <= m;
        blk_data <= d;
        @(posedge hclk);
        {sync_good, tune_start, tune_step, tune_done, band_end, lock_fail, blk_valid} <= 7'h0;
        repeat (3) @(posedge hclk);
    endtask
    // compare threshold: plain, or hysteresis after an algorithm
    function automatic logic [4:0] thr(input logic [1:0] fl, input logic hs, input logic af, input logic hy);
        if (!hy) return {1'b0, fl, 2'h0};
        if (fl == 2'h3 && !af) return 5'h0;
        return {1'b0, fl, 2'h0} + (hs ? 5'h2 : 5'h1);
    endfunction
    initial begin
        {hresetn, hwrite, tune_start, tune_step, tune_done, tune_is_af, band_end, lock_fail} = '0;
        {blk_valid, blk_is_a, blk_is_b, sync_good, sync_lost, pull_q, htrans, haddr, hwdata, level_adc, blk_data} = '0;
        void'($urandom(32'h00BA));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 8; i++) rc(8'(i * 4), (i == 4) ? 32'h4 : 32'h0, 32'hFFFF_FFFF);
        $display("end reset");
        // level compare, plain and hysteresis, corner first
        for (int i = 0; i < 8; i++) begin
            f = (i < 2) ? 2'h3 : 2'($urandom);
            h = 1'($urandom);
            level_adc <= (i < 2) ? 4'h0 : 4'($urandom);
            tune_is_af <= (i < 2) ? 1'b0 : 1'($urandom);
            xf(1'b1, 8'h08, {29'h0, h, f});
            ev(7'h20, 16'h0);
            ev(i[0] ? 7'h08 : 7'h10, 16'h0);
            if (i[0]) xf(1'b0, 8'h04, 32'h0);
            repeat (25) @(posedge hclk);
            rc(8'h00, {31'h0, {1'b0, level_adc} < thr(f, h, tune_is_af, i[0])}, 32'h1);
            rc(8'h0C, {28'h0, level_adc}, 32'hF);
        end
        level_adc <= 4'hF;
        ev(7'h20, 16'h0);
        $display("end level");
        // flags, masks and the shared line
        xf(1'b1, 8'h04, 32'h6);
        ev(7'h04, 16'h0);
        ck({31'h0, oe}, 32'h1);
        ck({31'h0, line}, 32'h0);
        ev(7'h08, 16'h0);
        ev(7'h04, 16'h0);
        rc(8'h00, 32'h6, 32'h1F);
        rc(8'h04, 32'h6, 32'h1F);
        rc(8'h00, 32'h0, 32'h1F);
        rc(8'h04, 32'h0, 32'h1F);
        ck({31'h0, oe}, 32'h0);
        ev(7'h02, 16'h0);
        ck({31'h0, oe}, 32'h0);
        rc(8'h00, 32'h4, 32'h1F);
        pull_q <= 1'b1;
        repeat (6) @(posedge hclk);
        rc(8'h10, 32'h0, 32'h4);
        pull_q <= 1'b0;
        $display("end irq");
        // standard mode: shift, overflow, buffered block
        xf(1'b1, 8'h04, 32'h8);
        for (int k = 0; k < 3; k++) begin
            bk[k] = 16'($urandom);
            ev(7'h01, bk[k]);
            if (k == 0) ck({31'h0, oe}, 32'h1);
        end
        rc(8'h00, 32'h8, 32'h8);
        rc(8'h10, 32'h1, 32'h1);
        rc(8'h18, {16'h0, bk[0]}, 32'hFFFF);
        rc(8'h14, {16'h0, bk[1]}, 32'hFFFF);
        rc(8'h10, 32'h0, 32'h1);
        rc(8'h14, {16'h0, bk[2]}, 32'hFFFF);
        rc(8'h00, 32'h0, 32'h8);
        $display("end std");
        // halved rate: align, then two blocks per flag
        xf(1'b1, 8'h08, 32'h10);
        rd = 32'h0;
        repeat (2) begin
            if (!rd[3]) begin
                ev(7'h01, 16'($urandom));
                xf(1'b0, 8'h00, 32'h0);
            end
        end
        xf(1'b0, 8'h14, 32'h0);
        ev(7'h01, 16'h0);
        rc(8'h00, 32'h0, 32'h8);
        ev(7'h01, 16'h0);
        rc(8'h00, 32'h8, 32'h8);
        $display("end half");
        // fast ident: withheld until an A block, then sync
        xf(1'b1, 8'h08, 32'h08);
        xf(1'b0, 8'h14, 32'h0);
        ev(7'h01, 16'h0);
        rc(8'h00, 32'h0, 32'h8);
        blk_is_a <= 1'b1;
        bk[0] = 16'($urandom);
        ev(7'h01, bk[0]);
        rc(8'h00, 32'h8, 32'h8);
        rc(8'h14, {16'h0, bk[0]}, 32'hFFFF);
        ev(7'h40, 16'h0);
        rc(8'h10, 32'h2, 32'h2);
        xf(1'b0, 8'h14, 32'h0);
        blk_is_a <= 1'b0;
        ev(7'h01, 16'h0);
        rc(8'h00, 32'h8, 32'h8);
        $display("end fast");
        // lock lost: flag and line, its mask survives the mask read
        xf(1'b1, 8'h04, 32'h10);
        sync_lost <= 1'b1;
        @(posedge hclk);
        sync_lost <= 1'b0;
        repeat (3) @(posedge hclk);
        ck({31'h0, oe}, 32'h1);
        rc(8'h00, 32'h10, 32'h10);
        rc(8'h04, 32'h10, 32'h1F);
        rc(8'h04, 32'h10, 32'h1F);
        rc(8'h00, 32'h0, 32'h10);
        rc(8'h10, 32'h0, 32'h2);
        $display("end lock");
        stop_test();
    end
endmodule // rtf_flags_tb
`default_nettype wire
